// file: logic/iam_irq_accept.sv
// Interrupt acceptance flags, per-source control registers and memory decode
//
// Functional notes
// - Maskable interrupts are blocked while the enable flag is 0.
// - Acknowledging any interrupt clears the enable flag.
// - Stack select 0 picks the interrupt stack, 1 the user stack.
// - Hardware acknowledge or software interrupt 0 to 31 clears stack select.
// - Processor priority level is three bits, levels 0 to 7.
// - A request is accepted only above the processor priority level.
// - Reserved flag bit: software writes 0, reads need not be defined.
// - Decoder spans the whole 20-bit, 1-Mbyte space.
// - Program ROM ends at 0FFFFh; 16 Kbyte starts at 0C000h.
// - Fixed vector table spans 0FFDCh to 0FFFFh, holding routine addresses.
// - RAM starts at 00400h; 1 Kbyte ends at 007FFh.
// - RAM holds the stack for calls and saved interrupt context.
// - Peripheral register area decodes from 00000h to 002FFh.
// - With data flash fitted it maps to 02400h through 02BFFh.
// - Each source has an 8-bit control register, low three bits reset 0.
// - External pin control registers also reset bits 4 and 5 to 0.
//
// Added by the designer: the strobed register port.
`default_nettype none

module iam_irq_accept #(
    parameter bit HAS_DFLASH = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [19:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Peripheral request events, one-cycle pulses
    input wire logic [12:0] src_event,
    // CPU core acknowledge and software interrupt
    input wire logic cpu_int_ack,
    input wire logic sw_int_exec,
    input wire logic [5:0] sw_int_num,
    // CPU core address for decode
    input wire logic [19:0] cpu_addr,
    // Request to the CPU core
    output logic irq_request,
    output logic [3:0] irq_source,
    output logic [2:0] irq_level,
    // Processor state
    output logic int_enable,
    output logic stack_select,
    output logic [2:0] cpu_priority_level,
    output logic [15:0] active_sp,
    output logic sp_outside_ram,
    // Decoded region of cpu_addr, one cycle later
    output logic region_per,
    output logic region_ram,
    output logic region_dflash,
    output logic region_rom,
    output logic region_vector,
    output logic region_none
);

    logic [7:0] irq_ctrl [0:12];
    logic [12:0] pending;
    logic [12:0] next_pending;
    logic [12:0] ack_clear;
    logic [38:0] pri_flat;
    logic [15:0] interrupt_stack_pointer;
    logic [15:0] user_stack_pointer;
    logic win_valid;
    logic [3:0] win_idx;
    logic [2:0] win_lvl;
    logic [4:0] wr_ctrl;
    logic [4:0] rd_ctrl;
    logic dec_per;
    logic dec_ram;
    logic dec_dflash;
    logic dec_rom;
    logic dec_vector;
    logic dec_none;
    logic sp_in_ram;
    logic [7:0] next_rdata;
    logic sw_ssel_clear;

    // Returns {hit, index} for a per-source control register address
    function automatic logic [4:0] ctrl_lookup(input logic [19:0] addr);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 0; i < iam_pkg::SRC_COUNT; i++) begin
            if (addr == iam_pkg::CTRL_OFFSET[i]) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction

    assign wr_ctrl = ctrl_lookup(reg_addr);
    assign rd_ctrl = ctrl_lookup(reg_addr);

    // Per-source control registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < iam_pkg::SRC_COUNT; i++) begin
                irq_ctrl[i] <= iam_pkg::CTRL_RST;
            end
        end else if (reg_wr && wr_ctrl[4]) begin
            irq_ctrl[wr_ctrl[3:0]] <= reg_wdata;
        end
    end

    // Source priorities feed the picker
    genvar g;
    generate
        for (g = 0; g < iam_pkg::SRC_COUNT; g++) begin : g_pri
            assign pri_flat[g*3 +: 3] = irq_ctrl[g][2:0];
        end
    endgenerate

    // Pending requests: an event in the clearing cycle survives
    assign ack_clear = cpu_int_ack ? (13'h0001 << irq_source) : 13'h0000;
    assign next_pending = (pending & ~ack_clear) | src_event;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pending <= 13'h0000;
        end else begin
            pending <= next_pending;
        end
    end

    iam_prio_pick u_pick (
        .req(pending),
        .pri_flat(pri_flat),
        .ien(int_enable),
        .cur_lvl(cpu_priority_level),
        .valid(win_valid),
        .idx(win_idx),
        .lvl(win_lvl)
    );

    // Request to the core; dropped at once on acknowledge so that the
    // stale winner of the acknowledge cycle is never offered again
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_request <= 1'b0;
            irq_source <= 4'h0;
            irq_level <= 3'h0;
        end else begin
            irq_request <= win_valid && !cpu_int_ack;
            irq_source <= win_idx;
            irq_level <= win_lvl;
        end
    end

    assign sw_ssel_clear = sw_int_exec && (sw_int_num <= iam_pkg::SW_INT_SSEL_MAX);

    // Interrupt enable flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            int_enable <= iam_pkg::FLAG_IEN_RST;
        end else if (cpu_int_ack) begin
            int_enable <= 1'b0;
        end else if (reg_wr && reg_addr == iam_pkg::FLAG_ADDR) begin
            int_enable <= reg_wdata[iam_pkg::FLAG_IEN_BIT];
        end
    end

    // Stack select flag; hardware clears win over a software write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stack_select <= iam_pkg::FLAG_SSEL_RST;
        end else if (cpu_int_ack || sw_ssel_clear) begin
            stack_select <= 1'b0;
        end else if (reg_wr && reg_addr == iam_pkg::FLAG_ADDR) begin
            stack_select <= reg_wdata[iam_pkg::FLAG_SSEL_BIT];
        end
    end

    // Processor level rises to the accepted level so equal or lower
    // requests wait until software lowers it again
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpu_priority_level <= iam_pkg::LEVEL_RST;
        end else if (cpu_int_ack) begin
            cpu_priority_level <= irq_level;
        end else if (reg_wr && reg_addr == iam_pkg::FLAG_ADDR) begin
            cpu_priority_level <= reg_wdata[iam_pkg::FLAG_LVL_LSB +: 3];
        end
    end

    // Stack pointers, written a byte at a time
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            interrupt_stack_pointer <= iam_pkg::SP_RST;
            user_stack_pointer <= iam_pkg::SP_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                iam_pkg::INT_SP_LO_ADDR: begin
                    interrupt_stack_pointer[7:0] <= reg_wdata;
                end
                iam_pkg::INT_SP_HI_ADDR: begin
                    interrupt_stack_pointer[15:8] <= reg_wdata;
                end
                iam_pkg::USR_SP_LO_ADDR: begin
                    user_stack_pointer[7:0] <= reg_wdata;
                end
                iam_pkg::USR_SP_HI_ADDR: begin
                    user_stack_pointer[15:8] <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    assign active_sp = stack_select ? user_stack_pointer : interrupt_stack_pointer;

    // Stack must sit in RAM; a pointer elsewhere is flagged to the core
    iam_addr_decode #(
        .HAS_DFLASH(HAS_DFLASH)
    ) u_sp_decode (
        .addr({4'h0, active_sp}),
        .hit_per(),
        .hit_ram(sp_in_ram),
        .hit_dflash(),
        .hit_rom(),
        .hit_vector(),
        .hit_none()
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sp_outside_ram <= 1'b0;
        end else begin
            sp_outside_ram <= !sp_in_ram;
        end
    end

    // Core address decode, registered
    iam_addr_decode #(
        .HAS_DFLASH(HAS_DFLASH)
    ) u_cpu_decode (
        .addr(cpu_addr),
        .hit_per(dec_per),
        .hit_ram(dec_ram),
        .hit_dflash(dec_dflash),
        .hit_rom(dec_rom),
        .hit_vector(dec_vector),
        .hit_none(dec_none)
    );

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            region_per <= 1'b0;
            region_ram <= 1'b0;
            region_dflash <= 1'b0;
            region_rom <= 1'b0;
            region_vector <= 1'b0;
            region_none <= 1'b0;
        end else begin
            region_per <= dec_per;
            region_ram <= dec_ram;
            region_dflash <= dec_dflash;
            region_rom <= dec_rom;
            region_vector <= dec_vector;
            region_none <= dec_none;
        end
    end

    // Read mux; the reserved flag bit and unassigned addresses read 0
    always_comb begin
        next_rdata = 8'h00;
        if (rd_ctrl[4]) begin
            next_rdata = irq_ctrl[rd_ctrl[3:0]];
        end else begin
            case (reg_addr)
                iam_pkg::FLAG_ADDR: begin
                    next_rdata[iam_pkg::FLAG_IEN_BIT] = int_enable;
                    next_rdata[iam_pkg::FLAG_SSEL_BIT] = stack_select;
                    next_rdata[iam_pkg::FLAG_RSVD_BIT] = 1'b0;
                    next_rdata[iam_pkg::FLAG_LVL_LSB +: 3] = cpu_priority_level;
                end
                iam_pkg::PEND_LO_ADDR: begin
                    next_rdata = pending[7:0];
                end
                iam_pkg::PEND_HI_ADDR: begin
                    next_rdata = {3'h0, pending[12:8]};
                end
                iam_pkg::INT_SP_LO_ADDR: begin
                    next_rdata = interrupt_stack_pointer[7:0];
                end
                iam_pkg::INT_SP_HI_ADDR: begin
                    next_rdata = interrupt_stack_pointer[15:8];
                end
                iam_pkg::USR_SP_LO_ADDR: begin
                    next_rdata = user_stack_pointer[7:0];
                end
                iam_pkg::USR_SP_HI_ADDR: begin
                    next_rdata = user_stack_pointer[15:8];
                end
                iam_pkg::STATUS_ADDR: begin
                    next_rdata[iam_pkg::STAT_SP_RAM_BIT] = sp_in_ram;
                    next_rdata[iam_pkg::STAT_REQ_BIT] = irq_request;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    // Read data stands one cycle after the strobe and is zero otherwise
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule // iam_irq_accept

`default_nettype wire

// file: shared/iam_pkg.sv
// Constants shared by the interrupt acceptance and address decode logic
`default_nettype none

package iam_pkg;

    // Address space and bus widths
    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int SP_W = 16;
    localparam int PRI_W = 3;
    localparam int SRC_COUNT = 13;
    localparam int IDX_W = 4;

    // Memory map
    localparam logic [19:0] SPACE_LO = 20'h00000;
    localparam logic [19:0] SPACE_HI = 20'hFFFFF;
    localparam logic [19:0] PER_LO = 20'h00000;
    localparam logic [19:0] PER_HI = 20'h002FF;
    localparam logic [19:0] RAM_LO = 20'h00400;
    localparam logic [19:0] RAM_SIZE = 20'h00400;
    localparam logic [19:0] DFLASH_LO = 20'h02400;
    localparam logic [19:0] DFLASH_HI = 20'h02BFF;
    localparam logic [19:0] ROM_TOP = 20'h0FFFF;
    localparam logic [19:0] ROM_SIZE = 20'h04000;
    localparam logic [19:0] VECTOR_LO = 20'h0FFDC;

    // Per-source control registers, indexed by source number
    localparam logic [19:0] CTRL_OFFSET [0:SRC_COUNT-1] = '{
        20'h00047, 20'h0004A, 20'h0004D, 20'h0004E, 20'h00051,
        20'h00052, 20'h00056, 20'h00058, 20'h00059, 20'h0005A,
        20'h0005B, 20'h0005C, 20'h0005D
    };
    // Undefined bits after reset are loaded with zero as well
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Flag, pending, stack pointer and status registers
    localparam logic [19:0] FLAG_ADDR = 20'h002F0;
    localparam logic [19:0] PEND_LO_ADDR = 20'h002F2;
    localparam logic [19:0] PEND_HI_ADDR = 20'h002F3;
    localparam logic [19:0] INT_SP_LO_ADDR = 20'h002F4;
    localparam logic [19:0] INT_SP_HI_ADDR = 20'h002F5;
    localparam logic [19:0] USR_SP_LO_ADDR = 20'h002F6;
    localparam logic [19:0] USR_SP_HI_ADDR = 20'h002F7;
    localparam logic [19:0] STATUS_ADDR = 20'h002F8;

    // Flag register fields
    localparam int FLAG_IEN_BIT = 0;
    localparam int FLAG_SSEL_BIT = 1;
    localparam int FLAG_RSVD_BIT = 2;
    localparam int FLAG_LVL_LSB = 4;
    localparam logic FLAG_IEN_RST = 1'b0;
    localparam logic FLAG_SSEL_RST = 1'b0;
    localparam logic [2:0] LEVEL_RST = 3'h0;
    localparam logic [15:0] SP_RST = 16'h0000;

    // Status register fields
    localparam int STAT_SP_RAM_BIT = 0;
    localparam int STAT_REQ_BIT = 1;

    // Software interrupt numbers that also switch to the interrupt stack
    localparam logic [5:0] SW_INT_SSEL_MAX = 6'h1F;

endpackage : iam_pkg

`default_nettype wire

// file: logic/iam_addr_decode.sv
// Region decode of the 1-Mbyte address space
`default_nettype none

module iam_addr_decode #(
    parameter bit HAS_DFLASH = 1'b1
) (
    // Address in
    input wire logic [19:0] addr,
    // Region hits
    output logic hit_per,
    output logic hit_ram,
    output logic hit_dflash,
    output logic hit_rom,
    output logic hit_vector,
    output logic hit_none
);

    logic [19:0] ram_hi;
    logic [19:0] rom_lo;

    assign ram_hi = iam_pkg::RAM_LO + iam_pkg::RAM_SIZE - 20'h00001;
    assign rom_lo = iam_pkg::ROM_TOP - iam_pkg::ROM_SIZE + 20'h00001;

    // A 20-bit address always falls inside the space, so hit_none marks holes
    assign hit_per = (addr <= iam_pkg::PER_HI);
    assign hit_ram = (addr >= iam_pkg::RAM_LO) && (addr <= ram_hi);
    assign hit_dflash = HAS_DFLASH && (addr >= iam_pkg::DFLASH_LO)
        && (addr <= iam_pkg::DFLASH_HI);
    assign hit_rom = (addr >= rom_lo) && (addr <= iam_pkg::ROM_TOP);
    assign hit_vector = (addr >= iam_pkg::VECTOR_LO) && (addr <= iam_pkg::ROM_TOP);
    assign hit_none = !(hit_per || hit_ram || hit_dflash || hit_rom);

endmodule // iam_addr_decode

`default_nettype wire

// file: logic/iam_prio_pick.sv
// Picks the highest pending request above the processor level
`default_nettype none

module iam_prio_pick (
    // Requests and their levels
    input wire logic [12:0] req,
    input wire logic [38:0] pri_flat,
    // Processor state
    input wire logic ien,
    input wire logic [2:0] cur_lvl,
    // Winner
    output logic valid,
    output logic [3:0] idx,
    output logic [2:0] lvl
);

    always_comb begin
        valid = 1'b0;
        idx = 4'h0;
        lvl = cur_lvl;
        // Strict compare keeps ties with the lowest source number
        for (int i = 0; i < iam_pkg::SRC_COUNT; i++) begin
            if (req[i] && (pri_flat[i*3 +: 3] > lvl)) begin
                valid = 1'b1;
                idx = 4'(i);
                lvl = pri_flat[i*3 +: 3];
            end
        end
        if (!ien) begin
            valid = 1'b0;
        end
    end

endmodule // iam_prio_pick

`default_nettype wire

// file: tb/iam_irq_accept_sva.sv
// Assertion checker for the interrupt acceptance and decode block
`default_nettype none

module iam_irq_accept_sva #(
    parameter bit HAS_DFLASH = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Core side
    input wire logic cpu_int_ack,
    input wire logic sw_int_exec,
    input wire logic [5:0] sw_int_num,
    input wire logic [19:0] cpu_addr,
    // Device outputs
    input wire logic irq_request,
    input wire logic [2:0] irq_level,
    input wire logic int_enable,
    input wire logic stack_select,
    input wire logic [2:0] cpu_priority_level,
    input wire logic region_per,
    input wire logic region_ram,
    input wire logic region_dflash,
    input wire logic region_rom,
    input wire logic region_vector
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // A disable write may leave one stale request cycle, hence the past term
    AST_IEN_BLOCK: assert property (!int_enable && !$past(int_enable) |-> !irq_request)
        else $error("request while disabled");
    AST_ACK_IEN: assert property (cpu_int_ack && irq_request |=> !int_enable)
        else $error("enable not cleared on ack");
    AST_ACK_SSEL: assert property (cpu_int_ack && irq_request |=> !stack_select)
        else $error("stack select kept on ack");
    AST_SW_SSEL: assert property (sw_int_exec && sw_int_num <= 6'h1F |=> !stack_select)
        else $error("stack select kept on soft int");
    AST_ACK_LEVEL: assert property (cpu_int_ack && irq_request |=>
        cpu_priority_level == $past(irq_level)) else $error("level not loaded");
    AST_ABOVE_LEVEL: assert property (irq_request && $stable(cpu_priority_level) |->
        irq_level > cpu_priority_level) else $error("request not above level");
    AST_PER: assert property (!$past(rst) |-> region_per == ($past(cpu_addr) <= 20'h002FF))
        else $error("peripheral area decode");
    AST_RAM: assert property (!$past(rst) |-> region_ram ==
        ($past(cpu_addr) inside {[20'h00400:20'h007FF]})) else $error("ram decode");
    AST_DFLASH: assert property (!$past(rst) |-> region_dflash ==
        (HAS_DFLASH && $past(cpu_addr) inside {[20'h02400:20'h02BFF]})) else $error("df decode");
    AST_ROM: assert property (!$past(rst) |-> region_rom ==
        ($past(cpu_addr) inside {[20'h0C000:20'h0FFFF]})) else $error("rom decode");
    AST_VECTOR: assert property (!$past(rst) |-> region_vector ==
        ($past(cpu_addr) inside {[20'h0FFDC:20'h0FFFF]})) else $error("vector decode");

    COV_ACK: cover property (cpu_int_ack && irq_request ##1 !irq_request);
    COV_SW: cover property (sw_int_exec && sw_int_num <= 6'h1F);
    COV_VECTOR: cover property (region_vector);
endmodule // iam_irq_accept_sva

bind iam_irq_accept iam_irq_accept_sva #(.HAS_DFLASH(HAS_DFLASH)) u_sva (
    .sys_clk(sys_clk), .rst(rst), .cpu_int_ack(cpu_int_ack), .sw_int_exec(sw_int_exec),
    .sw_int_num(sw_int_num), .cpu_addr(cpu_addr), .irq_request(irq_request),
    .irq_level(irq_level), .int_enable(int_enable), .stack_select(stack_select),
    .cpu_priority_level(cpu_priority_level), .region_per(region_per),
    .region_ram(region_ram), .region_dflash(region_dflash), .region_rom(region_rom),
    .region_vector(region_vector));

`default_nettype wire

// file: tb/iam_core_model.sv
// Core model that acknowledges offered requests after a chosen delay
`default_nettype none

module iam_core_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Offered request and reply delay
    input wire logic irq_request,
    input wire logic [2:0] ack_delay,
    // Acknowledge
    output logic cpu_int_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] wait_cnt;

    // Never acknowledges a withdrawn request; one pulse per offer
    always_ff @(posedge sys_clk) begin
        if (rst || cpu_int_ack || !irq_request) begin
            cpu_int_ack <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (wait_cnt == ack_delay) begin
            cpu_int_ack <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule // iam_core_model

`default_nettype wire

// file: tb/iam_irq_accept_tb.sv
// Self-checking bench for the interrupt acceptance and decode block
`default_nettype none

module iam_irq_accept_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst, reg_wr, reg_rd, cpu_int_ack, sw_int_exec;
    logic [19:0] reg_addr, cpu_addr;
    logic [7:0] reg_wdata, reg_rdata, rd_val;
    logic [12:0] src_event, m_pend;
    logic [5:0] sw_int_num, region;
    logic [3:0] irq_source;
    logic [2:0] irq_level, cpu_priority_level, ack_delay, m_lvl;
    logic irq_request, int_enable, stack_select, sp_outside_ram, m_ien, m_ssel;
    logic [15:0] active_sp;
    logic [31:0] seed;
    logic [7:0] m_ctrl [0:12];
    logic [19:0] edge_addr [0:17] = '{20'h00000, 20'h002FF, 20'h00300, 20'h003FF,
        20'h00400, 20'h007FF, 20'h00800, 20'h023FF, 20'h02400, 20'h02BFF, 20'h02C00,
        20'h0BFFF, 20'h0C000, 20'h0FFDB, 20'h0FFDC, 20'h0FFFF, 20'h10000, 20'hFFFFF};
    int failures, samples_checked;

    iam_irq_accept dut_u (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_event(src_event), .cpu_int_ack(cpu_int_ack), .sw_int_exec(sw_int_exec),
        .sw_int_num(sw_int_num), .cpu_addr(cpu_addr), .irq_request(irq_request),
        .irq_source(irq_source), .irq_level(irq_level), .int_enable(int_enable),
        .stack_select(stack_select), .cpu_priority_level(cpu_priority_level),
        .active_sp(active_sp), .sp_outside_ram(sp_outside_ram), .region_per(region[0]),
        .region_ram(region[1]), .region_dflash(region[2]), .region_rom(region[3]),
        .region_vector(region[4]), .region_none(region[5]));
    iam_core_model core_u (.sys_clk(sys_clk), .rst(rst), .irq_request(irq_request),
        .ack_delay(ack_delay), .cpu_int_ack(cpu_int_ack));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    function automatic logic [5:0] exp_region(input logic [19:0] a);
        logic [5:0] r;
        r[0] = a <= 20'h002FF;
        r[1] = a >= 20'h00400 && a <= 20'h007FF;
        r[2] = a >= 20'h02400 && a <= 20'h02BFF;
        r[3] = a >= 20'h0C000 && a <= 20'h0FFFF;
        r[4] = a >= 20'h0FFDC && a <= 20'h0FFFF;
        r[5] = r[3:0] == 4'h0;
        return r;
    endfunction

    // Highest priority above the level wins; ties go to the lowest index
    function automatic int pick();
        int w;
        w = -1;
        for (int i = 12; i >= 0; i--)
            if (m_pend[i] && m_ien && m_ctrl[i][2:0] > m_lvl &&
                (w < 0 || m_ctrl[i][2:0] >= m_ctrl[w][2:0])) w = i;
        return w;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [19:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask

    task automatic wait_req(input logic lvl, input int n, output logic hit);
        hit = 1'b0;
        for (int k = 0; k < n && !hit; k++) begin
            @(posedge sys_clk);
            #1 hit = irq_request === lvl;
        end
    endtask

    initial begin
        int w;
        logic hit;
        failures = 0;
        samples_checked = 0;
        seed = 32'h094018D9;
        {rst, reg_wr, reg_rd, sw_int_exec} = 4'hF ^ 4'h7;
        {reg_addr, cpu_addr, reg_wdata, src_event, sw_int_num, ack_delay} = '0;
        {m_pend, m_ien, m_ssel, m_lvl} = '0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            rd(iam_pkg::CTRL_OFFSET[i]);
            check(rd_val & ((i inside {8, 9, 12}) ? 8'h37 : 8'h07), 8'h00);
            seed = xs(seed);
            m_ctrl[i] = seed[7:0];
            wr(iam_pkg::CTRL_OFFSET[i], m_ctrl[i]);
            rd(iam_pkg::CTRL_OFFSET[i]);
            check(rd_val, m_ctrl[i]);
        end
        // Unassigned peripheral addresses stay untouched; probe a hole above the area
        wr(20'h00300, 8'hFF);
        rd(20'h00300);
        check(rd_val, 8'h00);
        // Interrupt stack in RAM, user stack below it
        wr(iam_pkg::INT_SP_LO_ADDR, 8'h00);
        wr(iam_pkg::INT_SP_HI_ADDR, 8'h05);
        wr(iam_pkg::USR_SP_LO_ADDR, 8'h23);
        wr(iam_pkg::USR_SP_HI_ADDR, 8'h01);
        for (int i = 0; i < 40; i++) begin
            seed = xs(seed);
            @(posedge sys_clk);
            cpu_addr <= (i < 18) ? edge_addr[i] : seed[19:0];
            @(posedge sys_clk);
            #1 check(region, exp_region(cpu_addr));
        end
        for (int i = 0; i < 13; i++) begin
            seed = xs(seed);
            m_ctrl[i] = seed[7:0];
            ack_delay <= seed[13:11];
            {m_ien, m_ssel, m_lvl} = 5'h08;
            wr(iam_pkg::FLAG_ADDR, 8'h02);
            wr(iam_pkg::CTRL_OFFSET[i], m_ctrl[i]);
            @(posedge sys_clk);
            src_event <= 13'h0001 << i;
            @(posedge sys_clk);
            src_event <= 13'h0000;
            m_pend[i] = 1'b1;
            repeat (3) @(posedge sys_clk);
            #1 check(irq_request, 1'b0);
            m_ien = 1'b1;
            m_lvl = seed[18:16];
            // Reserved flag bit is always written as 0
            wr(iam_pkg::FLAG_ADDR, {1'b0, m_lvl, 4'h3});
            w = pick();
            wait_req(1'b1, 4, hit);
            check(hit, w >= 0);
            if (hit && w >= 0) begin
                check(irq_source, w);
                check(irq_level, m_ctrl[w][2:0]);
                wait_req(1'b0, 12, hit);
                if (!hit) begin
                    failures++;
                    report_and_stop();
                end
                {m_ien, m_ssel, m_lvl} = {2'b00, m_ctrl[w][2:0]};
                m_pend[w] = 1'b0;
            end
            check(active_sp, m_ssel ? 16'h0123 : 16'h0500);
            check({cpu_priority_level, stack_select, int_enable}, {m_lvl, m_ssel, m_ien});
            rd(iam_pkg::FLAG_ADDR);
            check(rd_val, {1'b0, m_lvl, 2'b00, m_ssel, m_ien});
            rd(iam_pkg::PEND_LO_ADDR);
            check(rd_val, m_pend[7:0]);
            rd(iam_pkg::PEND_HI_ADDR);
            check(rd_val, {3'h0, m_pend[12:8]});
        end
        for (int i = 0; i < 2; i++) begin
            wr(iam_pkg::FLAG_ADDR, 8'h02);
            @(posedge sys_clk);
            sw_int_num <= (i == 1) ? 6'h1F : 6'h20;
            sw_int_exec <= 1'b1;
            @(posedge sys_clk);
            sw_int_exec <= 1'b0;
            #1 check(stack_select, i == 0);
            rd(iam_pkg::STATUS_ADDR);
            check(rd_val, {7'h00, i == 1});
            check(sp_outside_ram, i == 0);
        end
        report_and_stop();
    end
endmodule // iam_irq_accept_tb

`default_nettype wire
